// >>> rtl/mic_pkg.sv
// Purpose: constants shared by the interrupt control block
// Assumes: one clk cycle equals one instruction cycle
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package mic_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int PC_W   = 13;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PENA    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PENB    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PREQA   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_PREQB   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_OPTION  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PINSEL  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_PWRSTAT = 8'h1c;

    // ==========================================================
    // irq_control_reg fields, plus the option edge bit and the power status brown-out bit
    localparam int CTRL_GIE  = 7;
    localparam int CTRL_PERIPHERAL_GROUP_ENABLE = 6;
    localparam int CTRL_TIMER0_ROLLOVER_ENABLE = 5;
    localparam int CTRL_XIE  = 4;
    localparam int CTRL_PCIE = 3;
    localparam int CTRL_T0F  = 2;
    localparam int CTRL_XF   = 1;
    localparam int CTRL_PCF  = 0;
    localparam int OPT_EDGE  = 6;
    localparam int PWR_BROWN = 0;

    // ==========================================================
    // reset values and implemented-bit masks
    localparam logic [REG_W-1:0] CTRL_RST    = 8'h00;
    localparam logic [REG_W-1:0] PEN_RST     = 8'h00;
    localparam logic [REG_W-1:0] OPTION_RST  = 8'hff;
    localparam logic [REG_W-1:0] PINSEL_RST  = 8'h00;
    localparam logic [REG_W-1:0] PWRSTAT_RST = 8'h04;
    localparam logic [REG_W-1:0] PWRSTAT_WM  = 8'h0f;
    localparam logic [REG_W-1:0] BANK_A_MASK = 8'h7f;
    localparam logic [REG_W-1:0] BANK_B_MASK = 8'hfd;

    // ==========================================================
    // program counter targets and reset kinds
    localparam logic [PC_W-1:0] PC_VECTOR = 13'h0004;
    localparam logic [PC_W-1:0] PC_RESET  = 13'h0000;

    typedef enum logic [1:0] {
        RST_POWER,
        RST_MASTER,
        RST_WATCHDOG,
        RST_BROWNOUT
    } mic_rst_kind_t;

endpackage

// >>> rtl/mic_irq_ctrl.sv
// Purpose: interrupt control for an 8-bit microcontroller core
// Assumes: clk is the instruction-cycle clock; core signals share clk
// Notes:   pins pass a three-stage synchroniser; apb answers with no wait
`timescale 1ns/10ps
`default_nettype none

module mic_irq_ctrl
    import mic_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [mic_pkg::ADDR_W-1:0] paddr,
    input  wire logic [mic_pkg::DATA_W-1:0] pwdata,
    output logic      [mic_pkg::DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  extIrqPin,
    input  wire logic [mic_pkg::REG_W-1:0]  portPins,
    input  wire logic                  timer0Rollover,
    input  wire logic [mic_pkg::REG_W-1:0]  periphEventA,
    input  wire logic [mic_pkg::REG_W-1:0]  periphEventB,
    input  wire logic                  retIrqExec,
    input  wire logic                  instrDone,
    input  wire logic                  sleepActive,
    input  wire logic                  resetEvent,
    input  wire mic_pkg::mic_rst_kind_t resetKind,
    output logic                       irqRequest,
    output logic                       vectorLoad,
    output logic                       pushReturn,
    output logic                       pcResetLoad,
    output logic      [mic_pkg::PC_W-1:0]   pcLoadValue,
    output logic                       wakeUp,
    output logic                       globalIrqEnable
);
    import mic_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} mic_state_t;

    function automatic logic [REG_W-1:0] flagNext(
        input logic             wr,
        input logic [REG_W-1:0] wval,
        input logic [REG_W-1:0] cur,
        input logic [REG_W-1:0] evt,
        input logic [REG_W-1:0] mask
    );
        flagNext = ((wr ? wval : cur) | evt) & mask;
    endfunction

    // ==========================================================
    // state
    mic_state_t       state_ff;
    mic_state_t       nxt_state;
    logic [REG_W-1:0] ctrl_ff;
    logic [REG_W-1:0] penA_ff;
    logic [REG_W-1:0] penB_ff;
    logic [REG_W-1:0] preqA_ff;
    logic [REG_W-1:0] preqB_ff;
    logic [REG_W-1:0] option_ff;
    logic [REG_W-1:0] pinSel_ff;
    logic [REG_W-1:0] pwrStat_ff;
    logic [REG_W-1:0] sleepEn_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic             xS1_ff;
    logic             xS2_ff;
    logic             xS3_ff;
    logic             xStable_ff;
    logic [REG_W-1:0] pS1_ff;
    logic [REG_W-1:0] pS2_ff;
    logic [REG_W-1:0] pS3_ff;
    logic [REG_W-1:0] pStable_ff;
    logic             pcResetLoad_ff;
    logic [PC_W-1:0]  pcLoadValue_ff;
    logic             wakeUp_ff;

    // ==========================================================
    // apb decode
    wire logic       wrPhase  = psel & penable & pwrite;
    wire logic       setup    = psel & ~penable;
    wire logic       hitCtrl  = (paddr == OFS_CTRL);
    wire logic       hitPenA  = (paddr == OFS_PENA);
    wire logic       hitPenB  = (paddr == OFS_PENB);
    wire logic       hitPreqA = (paddr == OFS_PREQA);
    wire logic       hitPreqB = (paddr == OFS_PREQB);
    wire logic       hitOpt   = (paddr == OFS_OPTION);
    wire logic       hitSel   = (paddr == OFS_PINSEL);
    wire logic       hitPwr   = (paddr == OFS_PWRSTAT);
    wire logic       mapped   = hitCtrl | hitPenA | hitPenB | hitPreqA | hitPreqB
                              | hitOpt | hitSel | hitPwr;
    wire logic [REG_W-1:0] wByte = pwdata[REG_W-1:0];
    wire logic       wrCtrl   = wrPhase & hitCtrl;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_ff;

    wire logic [REG_W-1:0] rdByte =
          hitCtrl  ? ctrl_ff
        : hitPenA  ? penA_ff
        : hitPenB  ? penB_ff
        : hitPreqA ? preqA_ff
        : hitPreqB ? preqB_ff
        : hitOpt   ? option_ff
        : hitSel   ? pinSel_ff
        : hitPwr   ? pwrStat_ff
        : 8'h00;

    // ==========================================================
    // pin edge detection
    wire logic xAgree   = (xS2_ff == xS3_ff);
    wire logic xChange  = xAgree & (xS3_ff != xStable_ff);
    wire logic xRise    = xChange & xS3_ff;
    wire logic xFall    = xChange & ~xS3_ff;
    wire logic xEdge    = option_ff[OPT_EDGE] ? xRise : xFall;
    wire logic [REG_W-1:0] pAgree  = ~(pS2_ff ^ pS3_ff);
    wire logic [REG_W-1:0] pChange = pAgree & (pS3_ff ^ pStable_ff);
    wire logic [REG_W-1:0] pStableNxt = (pS3_ff & pAgree) | (pStable_ff & ~pAgree);
    wire logic portEvent = |(pChange & pinSel_ff);

    // ==========================================================
    // request and service logic
    wire logic ctrlPend = (ctrl_ff[CTRL_TIMER0_ROLLOVER_ENABLE] & ctrl_ff[CTRL_T0F])
                        | (ctrl_ff[CTRL_XIE]  & ctrl_ff[CTRL_XF])
                        | (ctrl_ff[CTRL_PCIE] & ctrl_ff[CTRL_PCF]);
    wire logic periPend = |(preqA_ff & penA_ff) | |(preqB_ff & penB_ff);
    wire logic anyPend  = ctrlPend | (ctrl_ff[CTRL_PERIPHERAL_GROUP_ENABLE] & periPend);
    wire logic gieClearNow = wrCtrl & ~wByte[CTRL_GIE];
    wire logic gieOk    = ctrl_ff[CTRL_GIE] & ~gieClearNow;
    wire logic reqLevel = gieOk & anyPend;
    wire logic takeRun  = (state_ff == ST_RUN) & reqLevel & ~resetEvent;
    wire logic takeWake = (state_ff == ST_WAKE) & instrDone & reqLevel;
    wire logic take     = takeRun | takeWake;

    wire logic wakePeri = (preqA_ff & penA_ff) != 8'h00
                        || (preqB_ff & penB_ff) != 8'h00;
    wire logic wakeCtrl = (ctrl_ff[CTRL_XF] & sleepEn_ff[CTRL_XIE])
                        | (ctrl_ff[CTRL_PCF] & sleepEn_ff[CTRL_PCIE])
                        | (ctrl_ff[CTRL_T0F] & sleepEn_ff[CTRL_TIMER0_ROLLOVER_ENABLE]);
    wire logic wakeCond = (state_ff == ST_SLEEP) & (wakeCtrl | wakePeri);

    assign irqRequest      = reqLevel;
    assign vectorLoad      = take;
    assign pushReturn      = take;
    assign pcResetLoad     = pcResetLoad_ff;
    assign pcLoadValue     = pcLoadValue_ff;
    assign wakeUp          = wakeUp_ff;
    assign globalIrqEnable = ctrl_ff[CTRL_GIE];

    // ==========================================================
    // next control register value
    logic [REG_W-1:0] ctrlW;
    logic [REG_W-1:0] ctrlEvt;
    logic [REG_W-1:0] nxt_ctrl;
    always_comb begin
        ctrlW   = wrCtrl ? wByte : ctrl_ff;
        ctrlEvt = 8'h00;
        ctrlEvt[CTRL_T0F] = timer0Rollover;
        ctrlEvt[CTRL_XF]  = xEdge;
        ctrlEvt[CTRL_PCF] = portEvent;
        nxt_ctrl = ctrlW | ctrlEvt;
        if (retIrqExec) begin
            nxt_ctrl[CTRL_GIE] = 1'b1;
        end
        if (take) begin
            nxt_ctrl[CTRL_GIE] = 1'b0;
        end
        if (resetEvent) begin
            nxt_ctrl[CTRL_GIE] = 1'b0;
        end
    end

    // ==========================================================
    // sleep sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (sleepActive & ~take) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeCond) begin
                    nxt_state = ctrl_ff[CTRL_GIE] ? ST_WAKE : ST_RUN;
                end
            end
            ST_WAKE: begin
                if (instrDone) begin
                    nxt_state = ST_RUN;
                end
            end
        endcase
        if (resetEvent) begin
            nxt_state = ST_RUN;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff   <= CTRL_RST;
            penA_ff   <= PEN_RST;
            penB_ff   <= PEN_RST;
            preqA_ff  <= PEN_RST;
            preqB_ff  <= PEN_RST;
            option_ff <= OPTION_RST;
            pinSel_ff <= PINSEL_RST;
            state_ff  <= ST_RUN;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            penA_ff   <= (wrPhase & hitPenA) ? (wByte & BANK_A_MASK) : penA_ff;
            penB_ff   <= (wrPhase & hitPenB) ? (wByte & BANK_B_MASK) : penB_ff;
            preqA_ff  <= flagNext(wrPhase & hitPreqA, wByte, preqA_ff, periphEventA,
                                  BANK_A_MASK);
            preqB_ff  <= flagNext(wrPhase & hitPreqB, wByte, preqB_ff, periphEventB,
                                  BANK_B_MASK);
            option_ff <= (wrPhase & hitOpt) ? wByte : option_ff;
            pinSel_ff <= (wrPhase & hitSel) ? wByte : pinSel_ff;
            state_ff  <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwrStat_ff <= PWRSTAT_RST;
        end else if (resetEvent && resetKind == RST_BROWNOUT) begin
            pwrStat_ff <= pwrStat_ff & ~(8'h01 << PWR_BROWN);
        end else if (wrPhase & hitPwr) begin
            pwrStat_ff <= wByte & PWRSTAT_WM;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleepEn_ff <= CTRL_RST;
        end else if (state_ff == ST_RUN) begin
            sleepEn_ff <= ctrl_ff;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= '0;
        end else if (setup) begin
            prdata_ff <= {{(DATA_W-REG_W){1'b0}}, rdByte};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xS1_ff     <= 1'b0;
            xS2_ff     <= 1'b0;
            xS3_ff     <= 1'b0;
            xStable_ff <= 1'b0;
            pS1_ff     <= 8'h00;
            pS2_ff     <= 8'h00;
            pS3_ff     <= 8'h00;
            pStable_ff <= 8'h00;
        end else begin
            xS1_ff     <= extIrqPin;
            xS2_ff     <= xS1_ff;
            xS3_ff     <= xS2_ff;
            xStable_ff <= xAgree ? xS3_ff : xStable_ff;
            pS1_ff     <= portPins;
            pS2_ff     <= pS1_ff;
            pS3_ff     <= pS2_ff;
            pStable_ff <= pStableNxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pcResetLoad_ff <= 1'b1;
            pcLoadValue_ff <= PC_RESET;
            wakeUp_ff      <= 1'b0;
        end else begin
            pcResetLoad_ff <= resetEvent;
            pcLoadValue_ff <= resetEvent ? PC_RESET : PC_VECTOR;
            wakeUp_ff      <= wakeCond;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    gie_gate_a: assert property (vectorLoad |-> globalIrqEnable && irqRequest)
        else $error("vector taken while global enable was clear");
    reset_gie_a: assert property (resetEvent |=> !globalIrqEnable)
        else $error("reset left global enable set");
    take_clear_a: assert property (vectorLoad && !retIrqExec |=> !globalIrqEnable)
        else $error("service did not clear global enable");
    take_vec_a: assert property (vectorLoad |-> pcLoadValue == PC_VECTOR && pushReturn)
        else $error("service without vector value or push");
    ret_set_a: assert property (retIrqExec && !vectorLoad && !resetEvent
                                |=> globalIrqEnable)
        else $error("return did not set global enable");
    defer_clear_a: assert property (wrCtrl && !wByte[CTRL_GIE] |-> !vectorLoad)
        else $error("interrupt taken while enable was being cleared");
    pin_flag_a: assert property (xEdge |=> ctrl_ff[CTRL_XF])
        else $error("pin edge did not set pin flag");
    pin_mask_a: assert property (!ctrl_ff[CTRL_XIE] && !ctrl_ff[CTRL_PERIPHERAL_GROUP_ENABLE]
                                 && !ctrl_ff[CTRL_T0F] && !ctrl_ff[CTRL_PCF]
                                 |-> !irqRequest)
        else $error("request without an enabled source");
    timer_flag_a: assert property (timer0Rollover |=> ctrl_ff[CTRL_T0F])
        else $error("rollover did not set timer flag");
    pc_reset_a: assert property (resetEvent |=> pcResetLoad && pcLoadValue == PC_RESET)
        else $error("reset did not load program counter zero");
    brown_a: assert property (resetEvent && resetKind == RST_BROWNOUT
                              |=> !pwrStat_ff[PWR_BROWN])
        else $error("brown-out left status bit set");
    keep_pwr_a: assert property (resetEvent && resetKind != RST_BROWNOUT && !wrPhase
                                 |=> $stable(pwrStat_ff))
        else $error("other reset changed power status");
    pin_lat_a: assert property ($rose(xS2_ff) && option_ff[OPT_EDGE] && !xStable_ff
                                && ctrl_ff[CTRL_XIE] && ctrl_ff[CTRL_GIE] && !ctrl_ff[CTRL_XF]
                                && state_ff == ST_RUN && !wrPhase && !resetEvent
                                && !sleepActive
                                |-> ##2 vectorLoad)
        else $error("pin latency not as expected");
    wake_rec_a: assert property (wakeUp |-> (ctrl_ff & 8'h07) != 8'h00
                                 || preqA_ff != 8'h00 || preqB_ff != 8'h00)
        else $error("wake with no flag recorded");
    port_flag_a: assert property (portEvent |=> ctrl_ff[CTRL_PCF])
        else $error("port change did not set port flag");
    peri_flag_a: assert property (|(periphEventB & BANK_B_MASK) |=> preqB_ff != 8'h00)
        else $error("peripheral event did not set its flag");
    fall_flag_a: assert property (xFall && !option_ff[OPT_EDGE] |=> ctrl_ff[CTRL_XF])
        else $error("falling pin edge did not set pin flag");

endmodule // mic_irq_ctrl

`default_nettype wire

// >>> dv/mic_core_model.sv
// Purpose: behavioural processor core facing the interrupt block
// Assumes: one instruction per clk, or one per two clk when twoCycle is high
// Notes:   keeps the program counter, a return address and a stack depth
`timescale 1ns/10ps
`default_nettype none

module mic_core_model
    import mic_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     vectorLoad,
    input  wire logic                     pushReturn,
    input  wire logic                     pcResetLoad,
    input  wire logic [mic_pkg::PC_W-1:0] pcLoadValue,
    input  wire logic                     retIrqExec,
    input  wire logic                     sleepActive,
    input  wire logic                     twoCycle,
    output logic                          instrDone,
    output logic      [mic_pkg::PC_W-1:0] pc_ff,
    output logic      [mic_pkg::PC_W-1:0] retAddr_ff,
    output logic      [3:0]               depth_ff
);
    logic phase_ff;

    // ==========================================================
    // instruction pacing: nothing completes while asleep
    assign instrDone = !sleepActive && (!twoCycle || phase_ff);

    // ==========================================================
    // program counter and return stack
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_ff      <= '0;
            retAddr_ff <= '0;
            depth_ff   <= '0;
            phase_ff   <= 1'b0;
        end else begin
            phase_ff <= !phase_ff;
            if (pcResetLoad) begin
                pc_ff    <= pcLoadValue;
                depth_ff <= '0;
            end else if (vectorLoad && pushReturn) begin
                retAddr_ff <= pc_ff + 13'h1;
                depth_ff   <= depth_ff + 4'h1;
                pc_ff      <= pcLoadValue;
            end else if (retIrqExec) begin
                depth_ff <= depth_ff - 4'h1;
                pc_ff    <= retAddr_ff;
            end else if (instrDone) begin
                pc_ff <= pc_ff + 13'h1;
            end
        end
    end

endmodule // mic_core_model

`default_nettype wire

// >>> dv/mic_irq_ctrl_test.sv
// Purpose: self-checking bench for the interrupt control block
// Assumes: apb answers when pready is high; core model on the far side
// Notes:   one task per scenario; apb read data and error sampled at the rising edge, other outputs at the falling edge
`timescale 1ns/10ps
`default_nettype none

module mic_irq_ctrl_test;
    import mic_pkg::*;

    logic          clk, nrst, psel, penable, pwrite, extIrqPin, timer0Rollover;
    logic          retIrqExec, sleepActive, resetEvent, twoCycle, instrDone;
    logic          pready, pslverr, irqRequest, vectorLoad, pushReturn;
    logic          pcResetLoad, wakeUp, globalIrqEnable;
    logic [7:0]    paddr, portPins, periphEventA, periphEventB;
    logic [31:0]   pwdata, prdata;
    logic [12:0]   pcLoadValue, pc, retAddr;
    logic [3:0]    depth;
    mic_rst_kind_t resetKind;
    int            failures, num_checks;

    mic_irq_ctrl dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extIrqPin(extIrqPin),
        .portPins(portPins), .timer0Rollover(timer0Rollover),
        .periphEventA(periphEventA), .periphEventB(periphEventB),
        .retIrqExec(retIrqExec), .instrDone(instrDone), .sleepActive(sleepActive),
        .resetEvent(resetEvent), .resetKind(resetKind), .irqRequest(irqRequest),
        .vectorLoad(vectorLoad), .pushReturn(pushReturn), .pcResetLoad(pcResetLoad),
        .pcLoadValue(pcLoadValue), .wakeUp(wakeUp), .globalIrqEnable(globalIrqEnable));

    mic_core_model core (.clk(clk), .nrst(nrst), .vectorLoad(vectorLoad),
        .pushReturn(pushReturn), .pcResetLoad(pcResetLoad), .pcLoadValue(pcLoadValue),
        .retIrqExec(retIrqExec), .sleepActive(sleepActive), .twoCycle(twoCycle),
        .instrDone(instrDone), .pc_ff(pc), .retAddr_ff(retAddr), .depth_ff(depth));

    // ==========================================================
    // clock, verdict and watchdog
    always #4 clk = ~clk;

    task automatic close_out;
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, {24'h0, exp}, r);
    endtask

    task automatic wait_vec(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (vectorLoad !== 1'b1 && n < 12);
    endtask

    task automatic pulse_ret;
        @(posedge clk);
        retIrqExec <= 1'b1;
        @(posedge clk);
        retIrqExec <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd(OFS_CTRL, 8'h00, "ctrl reset");
        rd(OFS_PENA, PEN_RST, "enable a reset");
        rd(OFS_PENB, PEN_RST, "enable b reset");
        rd(OFS_OPTION, OPTION_RST, "option reset");
        rd(OFS_PINSEL, PINSEL_RST, "pin select reset");
        rd(OFS_PWRSTAT, PWRSTAT_RST, "power status reset");
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask

    task automatic t_flags;
        int n;
        @(posedge clk);
        timer0Rollover <= 1'b1;
        periphEventA   <= 8'hff;
        periphEventB   <= 8'hff;
        @(posedge clk);
        timer0Rollover <= 1'b0;
        periphEventA   <= 8'h00;
        periphEventB   <= 8'h00;
        rd(OFS_CTRL, 8'h04, "timer flag");
        rd(OFS_PREQA, BANK_A_MASK, "request a");
        rd(OFS_PREQB, BANK_B_MASK, "request b");
        wr(OFS_PENA, 8'hff);
        wr(OFS_PENB, 8'hff);
        wr(OFS_CTRL, 8'h80);
        @(negedge clk);
        chk("no group enable", 32'h0, {31'h0, irqRequest});
        wr(OFS_CTRL, 8'hc0);
        wait_vec(n);
        chk("group vector", 32'h1, {31'h0, vectorLoad});
        chk("push", 32'h1, {31'h0, pushReturn});
        @(posedge clk);
        @(negedge clk);
        chk("gie after take", 32'h0, {31'h0, globalIrqEnable});
        chk("pc vector", {19'h0, PC_VECTOR}, {19'h0, pc});
        pulse_ret;
        wait_vec(n);
        chk("retaken", 32'h1, {31'h0, vectorLoad});
        wr(OFS_PREQA, 8'h00);
        wr(OFS_PREQB, 8'h00);
        pulse_ret;
        @(negedge clk);
        chk("gie after return", 32'h1, {31'h0, globalIrqEnable});
        chk("no request", 32'h0, {31'h0, irqRequest});
        wr(OFS_CTRL, 8'h00);
        wr(OFS_PENA, 8'h00);
        wr(OFS_PENB, 8'h00);
    endtask

    task automatic t_pin;
        int n;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            twoCycle  <= m[0];
            extIrqPin <= 1'b0;
            wr(OFS_OPTION, 8'hff);
            wr(OFS_CTRL, 8'h90);
            @(posedge clk);
            extIrqPin <= 1'b1;
            wait_vec(n);
            chk("pin latency", 32'h1, {31'h0, (n - 1 >= 3 && n - 1 <= 4)});
            @(posedge clk);
            @(negedge clk);
            chk("pin pc", {19'h0, PC_VECTOR}, {19'h0, pc});
            chk("pin gie", 32'h0, {31'h0, globalIrqEnable});
            rd(OFS_CTRL, 8'h12, "pin flag");
            wr(OFS_CTRL, 8'h00);
        end
        wr(OFS_OPTION, 8'hbf);
        @(posedge clk);
        extIrqPin <= 1'b0;
        repeat (4) @(posedge clk);
        rd(OFS_CTRL, 8'h02, "falling edge");
        wr(OFS_CTRL, 8'h00);
        @(posedge clk);
        extIrqPin <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_CTRL, 8'h00, "rising ignored");
        @(posedge clk);
        extIrqPin <= 1'b0;
        wr(OFS_CTRL, 8'h82);
        @(negedge clk);
        chk("pin disabled", 32'h0, {31'h0, irqRequest});
        wr(OFS_CTRL, 8'h00);
        wr(OFS_OPTION, 8'hff);
        wr(OFS_PINSEL, 8'h01);
        @(posedge clk);
        portPins <= 8'h02;
        repeat (4) @(posedge clk);
        rd(OFS_CTRL, 8'h00, "unselected pin");
        @(posedge clk);
        portPins <= 8'h03;
        repeat (4) @(posedge clk);
        rd(OFS_CTRL, 8'h01, "port flag");
        wr(OFS_CTRL, 8'h00);
    endtask

    task automatic t_sleep(input logic g);
        int          n;
        logic [12:0] p;
        @(posedge clk);
        twoCycle <= 1'b0;
        wr(OFS_CTRL, g ? 8'h90 : 8'h10);
        @(posedge clk);
        sleepActive <= 1'b1;
        @(posedge clk);
        extIrqPin <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wakeUp !== 1'b1 && n < 12);
        chk("wake", 32'h1, {31'h0, wakeUp});
        p = pc;
        @(posedge clk);
        sleepActive <= 1'b0;
        if (g) begin
            wait_vec(n);
            @(posedge clk);
            @(negedge clk);
            chk("wake vector", {19'h0, PC_VECTOR}, {19'h0, pc});
            chk("wake return", {19'h0, p + 13'h1}, {19'h0, retAddr});
        end else begin
            repeat (4) @(negedge clk);
            chk("wake no gie", 32'h0, {31'h0, irqRequest});
        end
        rd(OFS_CTRL, 8'h12, "wake cause");
        wr(OFS_CTRL, 8'h00);
        @(posedge clk);
        extIrqPin <= 1'b0;
    endtask

    task automatic t_rst;
        logic [31:0] r;
        logic        e;
        wr(OFS_PWRSTAT, 8'h0f);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CTRL, 8'h80);
            @(posedge clk);
            resetEvent <= 1'b1;
            resetKind  <= mic_rst_kind_t'(k);
            @(posedge clk);
            resetEvent <= 1'b0;
            @(negedge clk);
            chk("reset load", 32'h1, {31'h0, pcResetLoad});
            chk("reset pc", 32'h0, {19'h0, pcLoadValue});
            chk("reset gie", 32'h0, {31'h0, globalIrqEnable});
            apb(1'b0, OFS_PWRSTAT, 32'h0, r, e);
            chk("brown bit", {31'h0, k != 3}, {31'h0, r[PWR_BROWN]});
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {psel, penable, pwrite, extIrqPin, timer0Rollover} = '0;
        {retIrqExec, sleepActive, resetEvent, twoCycle} = '0;
        {paddr, portPins, periphEventA, periphEventB} = '0;
        pwdata = '0;
        resetKind = RST_POWER;
        failures = 0;
        num_checks = 0;
        repeat (19) @(posedge clk);
        @(negedge clk);
        chk("por load", 32'h1, {31'h0, pcResetLoad});
        chk("por gie", 32'h0, {31'h0, globalIrqEnable});
        @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_flags;
        t_pin;
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_rst;
        close_out;
    end

endmodule // mic_irq_ctrl_test

`default_nettype wire
